// ### fcfe_defines.svh
`ifndef FCFE_DEFINES_SVH
`define FCFE_DEFINES_SVH

// register word offsets and byte addresses; channel registers repeat every stride
`define FCFE_CH_STRIDE    8'h10
`define FCFE_OFF_CFG      2'h0
`define FCFE_OFF_WRAP     2'h1
`define FCFE_OFF_LOAD     2'h2
`define FCFE_OFF_RESULT   2'h3
`define FCFE_ADDR_CTRL    8'h40
`define FCFE_ADDR_STATUS  8'h44

// configuration word fields
`define FCFE_CFG_MODE_HI  2
`define FCFE_CFG_MODE_LO  0
`define FCFE_CFG_EDGE     3
`define FCFE_CFG_PSUB_HI  5
`define FCFE_CFG_PSUB_LO  4
`define FCFE_CFG_WIN_HI   7
`define FCFE_CFG_WIN_LO   6
`define FCFE_CFG_CLR_HI   9
`define FCFE_CFG_CLR_LO   8
`define FCFE_CFG_LD_HI    11
`define FCFE_CFG_LD_LO    10
`define FCFE_CFG_DIS_HI   13
`define FCFE_CFG_DIS_LO   12
`define FCFE_CFG_QDIR     14

// control word: clear, preload, disable request bits per channel
`define FCFE_CTRL_CLR_LO  0
`define FCFE_CTRL_LD_LO   4
`define FCFE_CTRL_DIS_LO  8

// timing
`define FCFE_CLK_NS       8
`define FCFE_RES_US       1
`define FCFE_TICK_CYC     ((`FCFE_RES_US * 1000) / `FCFE_CLK_NS)
`define FCFE_MIN_EDGE_US  100
`define FCFE_US_PER_S     32'h000F4240
`define FCFE_WIN0_US      32'h00002710
`define FCFE_WIN1_US      32'h000186A0
`define FCFE_WIN2_US      32'h0007A120
`define FCFE_WIN3_US      32'h000F4240

`endif

// ### fcfe_pkg.sv
package fcfe_pkg;

    typedef enum logic [2:0] {
        FCFE_OFF   = 3'h0,
        FCFE_FREQ  = 3'h1,
        FCFE_TOT   = 3'h2,
        FCFE_PULSE = 3'h3,
        FCFE_QUAD  = 3'h4
    } fcfe_mode_type;

    typedef enum logic [1:0] {
        FCFE_HIGH = 2'h0,
        FCFE_LOW  = 2'h1,
        FCFE_FALL = 2'h2,
        FCFE_RISE = 2'h3
    } fcfe_sens_type;

    typedef enum logic [1:0] {
        FCFE_WID_HIGH = 2'h0,
        FCFE_WID_LOW  = 2'h1,
        FCFE_PER_RISE = 2'h2,
        FCFE_PER_FALL = 2'h3
    } fcfe_psub_type;

    typedef struct packed {
        logic [3:0]        s1;
        logic [3:0]        s2;
        logic [3:0]        s3;
        logic [3:0][15:0]  cfg;
        logic [3:0][31:0]  wrap;
        logic [3:0][31:0]  load;
        logic [3:0][31:0]  acc;
        logic [3:0][31:0]  result;
        logic [3:0][31:0]  tcnt;
        logic [3:0][31:0]  wcnt;
        logic [3:0]        armed;
        logic [11:0]       ctrl;
        logic [11:0]       ctrl_prev;
        logic [6:0]        tick_cnt;
        logic [31:0]       rdata;
        logic              slverr;
    } fcfe_state_type;

endpackage

// ### fcfe_top.sv
// Operation
// - four fast_count_input channels, each frequency, totalize or pulse mode; channels 0 and 2 also quadrature.
// - quadrature on channel 0 or 2 claims the next channel, which then stays idle.
// - each channel's result sits in its own program_measurement_register.
// - edges are timed and measured on a one microsecond tick.
// - totalize and pulse edge selections are taken as positive logic.
// - a clear request zeroes the accumulator; not offered for frequency or period.
// - a preload request loads the configured value; not offered for frequency or period.
// - while disable is active the counter does not advance.
// - clear, preload and disable each take high, low, falling or rising sensitivity.
// - frequency mode reports hertz using one of four sample windows.
// - totalize returns to zero after wrap minus one; wrap zero uses 32 bits.
// - pulse mode reports high width, low width or period in microsecond counts.
// - quadrature counts every edge of either phase that does not coincide with an edge of the other, direction from the leading phase.
//
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`include "fcfe_defines.svh"

module fcfe_top #(
    parameter logic [31:0] WIN0_US = `FCFE_WIN0_US,
    parameter logic [31:0] WIN1_US = `FCFE_WIN1_US,
    parameter logic [31:0] WIN2_US = `FCFE_WIN2_US,
    parameter logic [31:0] WIN3_US = `FCFE_WIN3_US
) (
    input  wire logic        CORE_CLK,
    input  wire logic        RST,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic [3:0]  COUNT_IN
);

    fcfe_pkg::fcfe_state_type q;
    fcfe_pkg::fcfe_state_type next_q;
    fcfe_pkg::fcfe_mode_type  mode_w [4];
    logic [3:0]               rise_w;
    logic [3:0]               fall_w;
    logic [3:0]               clr_w;
    logic [3:0]               ld_w;
    logic [3:0]               dis_w;
    logic                     tick;

    // a channel odd-numbered is claimed when its even neighbour runs quadrature
    function automatic fcfe_pkg::fcfe_mode_type eff_mode(input logic [3:0][15:0] cfg, input int c);
        logic [2:0] m;
        m = cfg[c][`FCFE_CFG_MODE_HI:`FCFE_CFG_MODE_LO];
        if (m > 3'h4) begin
            return fcfe_pkg::FCFE_OFF;
        end
        if (c[0] && (m == 3'h4 || cfg[c - 1][`FCFE_CFG_MODE_HI:`FCFE_CFG_MODE_LO] == 3'h4)) begin
            return fcfe_pkg::FCFE_OFF;
        end
        return fcfe_pkg::fcfe_mode_type'(m);
    endfunction

    function automatic logic trig_hit(input logic [1:0] sens, input logic cur, input logic prev);
        case (fcfe_pkg::fcfe_sens_type'(sens))
            fcfe_pkg::FCFE_HIGH: return cur;
            fcfe_pkg::FCFE_LOW:  return !cur;
            fcfe_pkg::FCFE_FALL: return prev && !cur;
            fcfe_pkg::FCFE_RISE: return !prev && cur;
            default:             return 1'b0;
        endcase
    endfunction

    function automatic logic [31:0] win_len(input logic [1:0] sel);
        case (sel)
            2'h0:    return WIN0_US;
            2'h1:    return WIN1_US;
            2'h2:    return WIN2_US;
            default: return WIN3_US;
        endcase
    endfunction

    assign tick = (q.tick_cnt == 7'(`FCFE_TICK_CYC - 1));

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : gen_ch
            assign mode_w[g] = eff_mode(q.cfg, g);
            // edges from the second and third stage only, never the first
            assign rise_w[g] = q.s2[g] && !q.s3[g];
            assign fall_w[g] = !q.s2[g] && q.s3[g];
            assign clr_w[g]  = trig_hit(q.cfg[g][`FCFE_CFG_CLR_HI:`FCFE_CFG_CLR_LO],
                                        q.ctrl[`FCFE_CTRL_CLR_LO + g], q.ctrl_prev[`FCFE_CTRL_CLR_LO + g]);
            assign ld_w[g]   = trig_hit(q.cfg[g][`FCFE_CFG_LD_HI:`FCFE_CFG_LD_LO],
                                        q.ctrl[`FCFE_CTRL_LD_LO + g], q.ctrl_prev[`FCFE_CTRL_LD_LO + g]);
            assign dis_w[g]  = trig_hit(q.cfg[g][`FCFE_CFG_DIS_HI:`FCFE_CFG_DIS_LO],
                                        q.ctrl[`FCFE_CTRL_DIS_LO + g], q.ctrl_prev[`FCFE_CTRL_DIS_LO + g]);
        end
    endgenerate

    always_comb begin
        logic        edge_hit;
        logic        bl;
        logic        al;
        logic        up;
        logic        any_a;
        logic        any_b;
        logic [31:0] cnt;
        logic [1:0]  psub;
        logic [1:0]  idx;
        logic [1:0]  off;
        logic        is_ch;
        logic        ok;
        edge_hit = 1'b0;
        bl       = 1'b0;
        al       = 1'b0;
        up       = 1'b0;
        any_a    = 1'b0;
        any_b    = 1'b0;
        cnt      = '0;
        psub     = '0;
        idx      = PADDR[5:4];
        off      = PADDR[3:2];
        is_ch    = (PADDR[7:6] == 2'h0);
        ok       = 1'b0;
        next_q   = q;
        next_q.s1        = COUNT_IN;
        next_q.s2        = q.s1;
        next_q.s3        = q.s2;
        next_q.ctrl_prev = q.ctrl;
        next_q.tick_cnt  = tick ? 7'h00 : q.tick_cnt + 7'h01;
        for (int c = 0; c < 4; c++) begin
            case (mode_w[c])
                fcfe_pkg::FCFE_FREQ: begin
                    // frequency ignores clear and preload
                    if (!dis_w[c]) begin
                        cnt = q.acc[c] + {31'h0, rise_w[c]};
                        next_q.acc[c] = cnt;
                        if (tick) begin
                            if (q.wcnt[c] >= win_len(q.cfg[c][`FCFE_CFG_WIN_HI:`FCFE_CFG_WIN_LO]) - 32'h1) begin
                                next_q.result[c] = cnt * (`FCFE_US_PER_S /
                                    win_len(q.cfg[c][`FCFE_CFG_WIN_HI:`FCFE_CFG_WIN_LO]));
                                next_q.acc[c]    = '0;
                                next_q.wcnt[c]   = '0;
                            end else begin
                                next_q.wcnt[c] = q.wcnt[c] + 32'h1;
                            end
                        end
                    end
                end
                fcfe_pkg::FCFE_TOT: begin
                    // edge choice is on the synchronised pin level, whatever the wiring polarity
                    edge_hit = q.cfg[c][`FCFE_CFG_EDGE] ? fall_w[c] : rise_w[c];
                    if (clr_w[c]) begin
                        next_q.acc[c] = '0;
                    end else if (ld_w[c]) begin
                        next_q.acc[c] = q.load[c];
                    end else if (edge_hit && !dis_w[c]) begin
                        if (q.wrap[c] != 32'h0 && q.acc[c] == q.wrap[c] - 32'h1) begin
                            next_q.acc[c] = '0;
                        end else begin
                            next_q.acc[c] = q.acc[c] + 32'h1;
                        end
                    end
                    next_q.result[c] = next_q.acc[c];
                end
                fcfe_pkg::FCFE_PULSE: begin
                    psub = q.cfg[c][`FCFE_CFG_PSUB_HI:`FCFE_CFG_PSUB_LO];
                    if (!dis_w[c]) begin
                        if (tick) begin
                            next_q.tcnt[c] = q.tcnt[c] + 32'h1;
                        end
                        case (fcfe_pkg::fcfe_psub_type'(psub))
                            fcfe_pkg::FCFE_WID_HIGH, fcfe_pkg::FCFE_WID_LOW: begin
                                al = (psub == 2'h0) ? rise_w[c] : fall_w[c];
                                bl = (psub == 2'h0) ? fall_w[c] : rise_w[c];
                                if (al) begin
                                    next_q.tcnt[c]  = '0;
                                    next_q.armed[c] = 1'b1;
                                end else if (bl && q.armed[c]) begin
                                    next_q.result[c] = q.tcnt[c];
                                end
                            end
                            default: begin
                                al = (psub == 2'h2) ? rise_w[c] : fall_w[c];
                                if (al) begin
                                    if (q.armed[c]) begin
                                        next_q.result[c] = q.tcnt[c];
                                    end
                                    next_q.tcnt[c]  = '0;
                                    next_q.armed[c] = 1'b1;
                                end
                            end
                        endcase
                    end
                    // width sub-modes accept clear and preload, period does not
                    if (!psub[1]) begin
                        if (clr_w[c]) begin
                            next_q.result[c] = '0;
                        end else if (ld_w[c]) begin
                            next_q.result[c] = q.load[c];
                        end
                    end
                end
                fcfe_pkg::FCFE_QUAD: begin
                    // phase a is this channel, phase b the claimed neighbour
                    al    = q.s2[c];
                    bl    = q.s2[(c + 1) % 4];
                    any_a = rise_w[c] || fall_w[c];
                    any_b = rise_w[(c + 1) % 4] || fall_w[(c + 1) % 4];
                    up    = (rise_w[c] && !bl) || (al && rise_w[(c + 1) % 4]) ||
                            (fall_w[c] && bl) || (!al && fall_w[(c + 1) % 4]);
                    up    = q.cfg[c][`FCFE_CFG_QDIR] ? up : !up;
                    if (clr_w[c]) begin
                        next_q.acc[c] = '0;
                    end else if (ld_w[c]) begin
                        next_q.acc[c] = q.load[c];
                    end else if ((any_a ^ any_b) && !dis_w[c]) begin
                        // simultaneous edges on both phases break the spacing limit and are dropped
                        if (up) begin
                            next_q.acc[c] = (q.wrap[c] != 32'h0 && q.acc[c] == q.wrap[c] - 32'h1) ?
                                            32'h0 : q.acc[c] + 32'h1;
                        end else begin
                            next_q.acc[c] = (q.wrap[c] != 32'h0 && q.acc[c] == 32'h0) ?
                                            q.wrap[c] - 32'h1 : q.acc[c] - 32'h1;
                        end
                    end
                    next_q.result[c] = next_q.acc[c];
                end
                default: begin
                    next_q.acc[c]    = '0;
                    next_q.result[c] = '0;
                    next_q.tcnt[c]   = '0;
                    next_q.wcnt[c]   = '0;
                    next_q.armed[c]  = 1'b0;
                end
            endcase
        end
        // apb: decode in setup, data and error registered for the access phase
        if (PSEL && !PENABLE) begin
            ok = (PADDR[1:0] == 2'h0) && (is_ch || PADDR == `FCFE_ADDR_CTRL ||
                 (PADDR == `FCFE_ADDR_STATUS && !PWRITE)) && !(is_ch && PWRITE && off == `FCFE_OFF_RESULT);
            next_q.slverr = !ok;
            next_q.rdata  = '0;
            if (ok && !PWRITE) begin
                if (!is_ch) begin
                    next_q.rdata = (PADDR == `FCFE_ADDR_CTRL) ? {20'h0, q.ctrl} : {24'h0, q.s2,
                        mode_w[3] != fcfe_pkg::FCFE_OFF || q.cfg[3][2:0] == 3'h0 && q.cfg[2][2:0] != 3'h4,
                        1'b1,
                        mode_w[1] != fcfe_pkg::FCFE_OFF || q.cfg[1][2:0] == 3'h0 && q.cfg[0][2:0] != 3'h4,
                        1'b1};
                end else begin
                    case (off)
                        `FCFE_OFF_CFG:  next_q.rdata = {16'h0, q.cfg[idx]};
                        `FCFE_OFF_WRAP: next_q.rdata = q.wrap[idx];
                        `FCFE_OFF_LOAD: next_q.rdata = q.load[idx];
                        default:        next_q.rdata = q.result[idx];
                    endcase
                end
            end
        end
        if (PSEL && PENABLE && PWRITE && !q.slverr) begin
            if (!is_ch) begin
                next_q.ctrl = PWDATA[11:0];
            end else begin
                case (off)
                    `FCFE_OFF_CFG:  next_q.cfg[idx]  = PWDATA[15:0];
                    `FCFE_OFF_WRAP: next_q.wrap[idx] = PWDATA;
                    `FCFE_OFF_LOAD: next_q.load[idx] = PWDATA;
                    default:        next_q.load[idx] = q.load[idx];
                endcase
            end
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign PRDATA  = q.rdata;
    assign PREADY  = 1'b1;
    assign PSLVERR = q.slverr && PSEL && PENABLE;

    // checks
    a_sync_two_stage: assert property (@(posedge CORE_CLK) disable iff (RST)
        ##2 q.s2 == $past(COUNT_IN, 2)) else $error("input synchroniser depth wrong");
    a_reset_clear: assert property (@(posedge CORE_CLK)
        RST |-> (q.acc == '0 && q.result == '0 && q.cfg == '0)) else $error("state not cleared in reset");
    a_tick_spacing: assert property (@(posedge CORE_CLK) disable iff (RST)
        tick |=> !tick [*8]) else $error("microsecond tick too frequent");
    a_claimed_idle: assert property (@(posedge CORE_CLK) disable iff (RST)
        mode_w[2] == fcfe_pkg::FCFE_QUAD |=> ##1 q.result[3] == '0) else $error("claimed channel active");
    a_tot_wrap: assert property (@(posedge CORE_CLK) disable iff (RST)
        mode_w[0] == fcfe_pkg::FCFE_TOT && rise_w[0] && !q.cfg[0][`FCFE_CFG_EDGE] && !clr_w[0] && !ld_w[0]
        && !dis_w[0] && q.wrap[0] != 32'h0 && q.acc[0] == q.wrap[0] - 32'h1 |=> q.acc[0] == 32'h0)
        else $error("totalize did not wrap");
    a_tot_rise_count: assert property (@(posedge CORE_CLK) disable iff (RST)
        mode_w[0] == fcfe_pkg::FCFE_TOT && rise_w[0] && !q.cfg[0][`FCFE_CFG_EDGE] && !clr_w[0] && !ld_w[0]
        && !dis_w[0] && q.wrap[0] == 32'h0 |=> q.acc[0] == $past(q.acc[0]) + 32'h1)
        else $error("rising edge not counted");
    a_clear_zero: assert property (@(posedge CORE_CLK) disable iff (RST)
        mode_w[2] == fcfe_pkg::FCFE_QUAD && clr_w[2] |=> q.acc[2] == 32'h0 && q.result[2] == 32'h0)
        else $error("clear did not zero");
    a_preload_value: assert property (@(posedge CORE_CLK) disable iff (RST)
        mode_w[0] == fcfe_pkg::FCFE_TOT && !clr_w[0] && ld_w[0] |=> q.acc[0] == $past(q.load[0]))
        else $error("preload value missing");
    a_disable_hold: assert property (@(posedge CORE_CLK) disable iff (RST)
        mode_w[0] == fcfe_pkg::FCFE_TOT && dis_w[0] && !clr_w[0] && !ld_w[0] |=> $stable(q.acc[0]))
        else $error("counter advanced while disabled");
    a_quad_up: assert property (@(posedge CORE_CLK) disable iff (RST)
        mode_w[2] == fcfe_pkg::FCFE_QUAD && !q.cfg[2][`FCFE_CFG_QDIR] && rise_w[3] && !q.s2[2] && !rise_w[2]
        && !fall_w[2] && !clr_w[2] && !ld_w[2] && !dis_w[2] && q.wrap[2] == 32'h0
        |=> q.acc[2] == $past(q.acc[2]) + 32'h1) else $error("quadrature up count wrong");
    c_freq_window: cover property (@(posedge CORE_CLK) disable iff (RST)
        mode_w[0] == fcfe_pkg::FCFE_FREQ && tick && q.wcnt[0] == 32'h0 && q.result[0] != 32'h0);
    c_pulse_result: cover property (@(posedge CORE_CLK) disable iff (RST)
        mode_w[0] == fcfe_pkg::FCFE_PULSE && q.armed[0] && fall_w[0]);
    c_quad_down: cover property (@(posedge CORE_CLK) disable iff (RST)
        mode_w[2] == fcfe_pkg::FCFE_QUAD && fall_w[3]);
    c_apb_error: cover property (@(posedge CORE_CLK) disable iff (RST) PSLVERR);

endmodule

// ### fcfe_source.sv
`timescale 1ns/1ps
module fcfe_source #(
    parameter int GAP = 12500
) (
    input  wire logic       CORE_CLK,
    input  wire logic       RST,
    input  wire logic       RUN,
    output logic      [3:0] PINS,
    output logic      [7:0] STEPS
);
    logic [15:0] gap_cnt;
    logic [1:0]  phase;

    // gray steps move one pin of a pair at a time, so each pin sees two gaps between its own edges
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            gap_cnt <= 16'h0000;
            phase   <= 2'h0;
            STEPS   <= 8'h00;
        end else if (!RUN) begin
            gap_cnt <= 16'h0000;
        end else if (gap_cnt == 16'(GAP - 1)) begin
            gap_cnt <= 16'h0000;
            phase   <= phase + 2'h1;
            STEPS   <= STEPS + 8'h01;
        end else begin
            gap_cnt <= gap_cnt + 16'h0001;
        end
    end

    // pin 1 of each pair leads pin 0; positive logic wiring, so no edge inversion is needed
    assign PINS = {phase[1] ^ phase[0], phase[1], phase[1] ^ phase[0], phase[1]};
endmodule

// ### high_speed_counter_front_end_tb.sv
`timescale 1ns/1ps
module high_speed_counter_front_end_tb;
    localparam int GAP = 12500;
    logic        clk;
    logic        rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        run;
    logic [3:0]  pins;
    logic [7:0]  steps;
    logic [31:0] q;
    logic        e;
    int          n_fail = 0;
    int          n_checks = 0;

    fcfe_top i_dut (.CORE_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .COUNT_IN(pins));
    fcfe_source #(.GAP(GAP)) i_src (.CORE_CLK(clk), .RST(rst), .RUN(run), .PINS(pins), .STEPS(steps));

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
        n_checks++;
        if (g !== x) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", s, x, g);
        end
    endtask

    // tick phase against the edges is unknown, so a width may land one count either way
    task automatic chk_rng(input string s, input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] g);
        n_checks++;
        if ((g >= lo && g <= hi) !== 1'h1) begin
            n_fail++;
            $display("wrong value %s expected %h to %h seen %h", s, lo, hi, g);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'h1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'h1 && k < 16);
        q = prdata;
        e = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
        if (pready !== 1'h1) begin
            n_fail++;
            $display("wrong value pready expected 1 seen %b", pready);
            end_sim();
        end
    endtask

    task automatic rdc(input string s, input logic [7:0] a, input logic [31:0] x, input logic xe);
        apb(1'h0, a, 32'h00000000);
        chk(s, x, q);
        chk({s, " err"}, {31'h0, xe}, {31'h0, e});
    endtask

    task automatic wrc(input string s, input logic [7:0] a, input logic [31:0] d, input logic xe);
        apb(1'h1, a, d);
        chk({s, " err"}, {31'h0, xe}, {31'h0, e});
    endtask

    task automatic run_steps(input int n);
        logic [7:0] goal;
        int         k;
        goal = steps + 8'(n);
        k = 0;
        run <= 1'h1;
        while (steps !== goal && k < (n + 1) * GAP) begin
            @(posedge clk);
            k++;
        end
        run <= 1'h0;
        if (steps !== goal) begin
            n_fail++;
            $display("wrong value steps expected %h seen %h", goal, steps);
            end_sim();
        end
        repeat (20) @(posedge clk);
    endtask

    initial begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end

    initial begin
        rst = 1'h1;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        run = 1'h0;
        repeat (20) @(posedge clk);
        rst <= 1'h0;
        rdc("cfg0 reset", 8'h00, 32'h00000000, 1'h0);
        rdc("result0 reset", 8'h0C, 32'h00000000, 1'h0);
        rdc("status reset", 8'h44, 32'h0000000F, 1'h0);
        rdc("unmapped", 8'h48, 32'h00000000, 1'h1);
        wrc("result write", 8'h0C, 32'h00000005, 1'h1);
        rdc("result0 kept", 8'h0C, 32'h00000000, 1'h0);
        $display("test reset and map done");
        wrc("cfg0", 8'h00, 32'h00000C02, 1'h0);
        wrc("wrap0", 8'h04, 32'h00000005, 1'h0);
        wrc("load0", 8'h08, 32'h00000004, 1'h0);
        wrc("cfg1", 8'h10, 32'h00000003, 1'h0);
        wrc("cfg2", 8'h20, 32'h00000004, 1'h0);
        wrc("ctrl preload", 8'h40, 32'h00000010, 1'h0);
        rdc("preloaded", 8'h0C, 32'h00000004, 1'h0);
        rdc("status claim", 8'h44, 32'h00000007, 1'h0);
        wrc("ctrl idle", 8'h40, 32'h00000000, 1'h0);
        $display("test setup done");
        run_steps(4);
        rdc("totalize wrap", 8'h0C, 32'h00000000, 1'h0);
        apb(1'h0, 8'h1C, 32'h00000000);
        chk_rng("pulse high", 32'h000000C7, 32'h000000C9, q);
        rdc("quad count", 8'h2C, 32'h00000004, 1'h0);
        rdc("ch3 claimed", 8'h3C, 32'h00000000, 1'h0);
        rdc("levels low", 8'h44, 32'h00000007, 1'h0);
        $display("test measure done");
        wrc("ctrl hold", 8'h40, 32'h00000104, 1'h0);
        run_steps(2);
        rdc("disabled", 8'h0C, 32'h00000000, 1'h0);
        rdc("cleared", 8'h2C, 32'h00000000, 1'h0);
        rdc("levels high", 8'h44, 32'h000000F7, 1'h0);
        $display("test hold done");
        end_sim();
    end
endmodule
